//--- rtl/addr_cfg_pkg.sv
// Package with register offsets, field layout and bus constants.
package addr_cfg_pkg;
  localparam logic [3:0] OFS_BUS_CONTROL_TWO = 4'h0;
  localparam logic [3:0] OFS_OWN_ADDR_LOW = 4'h1;
  localparam logic [3:0] OFS_MATCH_STATUS = 4'h2;
  localparam int BIT_GENERAL_CALL_ACCEPT = 7;
  localparam int BIT_ADDRESS_LENGTH_SELECT = 6;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hC7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OWN_LOW_RESET = 8'h00;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
endpackage

//--- rtl/line_sync.sv
// Two-flop synchroniser for one bus line.
`timescale 1ns/1ps
module line_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= 1'b1;
      q_out <= 1'b1;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule // line_sync

//--- rtl/i2c_slave_address_config.sv
// Slave address configuration register and address match monitor.
//
// Function
// [RQ1] General call accept clear: general call address and its data ignored.
// [RQ2] General call accept set: general call recognised, following bytes taken.
// [RQ3] Length select chooses 7-bit match when clear, 10-bit when set.
// [RQ4] Software sets length select before slave operation begins.
// [RQ5] Three high address bits form own address top in 10-bit mode.
// [RQ6] Bits 5, 4 and 3 always read zero.
// [RQ7] Control register readable and writable at any time.
// [RQ8] Transaction is START, address, data, then STOP.
// [RQ9] 10-bit compare uses high bits with eight low own-address bits.
`timescale 1ns/1ps
module i2c_slave_address_config
  import addr_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port.
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Two-wire bus lines, observed only.
  input wire logic scl_in,
  input wire logic sda_in,
  // Match results and received data byte.
  output logic addr_match_out,
  output logic gcall_match_out,
  output logic data_strobe_out,
  output logic [7:0] data_out
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] own_low_r;
  logic scl_s, sda_s, scl_d_r, sda_d_r;
  typedef enum {IDLE, ADDR1, ADDR2, DATA, SKIP} state_t;
  state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [1:0] sticky_r;

  line_sync u_scl (.clk_in(clk_in), .rst_in(rst_in), .d_in(scl_in),
    .q_out(scl_s));
  line_sync u_sda (.clk_in(clk_in), .rst_in(rst_in), .d_in(sda_in),
    .q_out(sda_s));

  wire gc_en = ctrl_r[BIT_GENERAL_CALL_ACCEPT];
  wire ten_bit = ctrl_r[BIT_ADDRESS_LENGTH_SELECT];
  wire [10:0] own_addr = {ctrl_r[2:0], own_low_r}; // RQ5 RQ9
  wire wr_ctrl = wr_in && addr_in == OFS_BUS_CONTROL_TWO; // RQ7
  wire wr_low = wr_in && addr_in == OFS_OWN_ADDR_LOW;
  wire [7:0] ctrl_nxt = wdata_in & CTRL_WRITE_MASK; // RQ6
  // Unmapped offsets read as zero, so software can probe the map safely.
  wire [7:0] rd_mux =
    addr_in == OFS_BUS_CONTROL_TWO ? (ctrl_r & CTRL_WRITE_MASK) : // RQ6
    addr_in == OFS_OWN_ADDR_LOW ? own_low_r :
    addr_in == OFS_MATCH_STATUS ? {6'h00, sticky_r} : 8'h00;

  // ---------------------------------------------------------------
  // Bus conditions
  // ---------------------------------------------------------------
  wire start_ev = scl_s && scl_d_r && sda_d_r && !sda_s; // RQ8
  wire stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s; // RQ8
  wire rise = scl_s && !scl_d_r;
  wire [7:0] byte_nxt = {shift_r[6:0], sda_s};
  wire byte_done = rise && bit_cnt_r == 4'd7;
  wire ack_done = rise && bit_cnt_r == 4'd8;
  wire is_gc = byte_nxt[7:1] == GENERAL_CALL_ADDR;
  wire hit7 = !ten_bit && byte_nxt[7:1] == own_addr[6:0]; // RQ3
  wire hit10a = ten_bit && byte_nxt[7:3] == TEN_BIT_PREFIX && // RQ3
    byte_nxt[2:1] == own_addr[9:8];
  wire hit10b = byte_nxt == own_addr[7:0]; // RQ9
  // A 10-bit header carries only two high bits, so an own address with
  // bit 10 set can never be reached and is treated as a permanent miss.
  wire own_ten_ok = own_addr[10] == 1'b0;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RESET;
      own_low_r <= OWN_LOW_RESET;
      rdata_out <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_r <= ctrl_nxt;
      if (wr_low) own_low_r <= wdata_in;
      rdata_out <= rd_in ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= IDLE;
      bit_cnt_r <= 4'd0;
      shift_r <= 8'h00;
      addr_match_out <= 1'b0;
      gcall_match_out <= 1'b0;
      data_strobe_out <= 1'b0;
      data_out <= 8'h00;
      sticky_r <= 2'b00;
    end else begin
      // The block only watches the lines and never drives the ack slot.
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      data_strobe_out <= 1'b0;
      if (start_ev) begin
        state_r <= ADDR1;
        bit_cnt_r <= 4'd0;
        addr_match_out <= 1'b0;
        gcall_match_out <= 1'b0;
      end else if (stop_ev) begin
        state_r <= IDLE;
        addr_match_out <= 1'b0;
        gcall_match_out <= 1'b0;
      end else if (byte_done) begin
        shift_r <= byte_nxt;
        bit_cnt_r <= 4'd8;
        case (state_r)
          ADDR1: begin
            if (is_gc && gc_en) begin
              gcall_match_out <= 1'b1; // RQ2
              sticky_r[1] <= 1'b1;
              state_r <= DATA;
            end else if (hit7) begin
              addr_match_out <= 1'b1;
              sticky_r[0] <= 1'b1;
              state_r <= DATA;
            end else if (hit10a && own_ten_ok) begin
              state_r <= ADDR2;
            end else begin
              state_r <= SKIP; // RQ1
            end
          end
          ADDR2: begin
            if (hit10b) begin
              addr_match_out <= 1'b1;
              sticky_r[0] <= 1'b1;
              state_r <= DATA;
            end else begin
              state_r <= SKIP;
            end
          end
          DATA: begin
            data_out <= byte_nxt;
            data_strobe_out <= 1'b1; // RQ2
          end
          default: state_r <= state_r;
        endcase
      end else if (ack_done) begin
        bit_cnt_r <= 4'd0;
      end else if (rise) begin
        shift_r <= byte_nxt;
        bit_cnt_r <= bit_cnt_r + 4'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reserved_zero: assert property ( // RQ6
    @(posedge clk_in) disable iff (rst_in)
    $past(rd_in) && $past(addr_in) == OFS_BUS_CONTROL_TWO
    |-> rdata_out[5:3] == 3'b000)
    else $error("Reserved bits read nonzero.");
  a_gc_blocked: assert property ( // RQ1
    @(posedge clk_in) disable iff (rst_in)
    $rose(gcall_match_out) |-> $past(gc_en))
    else $error("General call taken while disabled.");
  a_seven_match: assert property ( // RQ3
    @(posedge clk_in) disable iff (rst_in)
    $rose(addr_match_out) && $past(state_r) == ADDR1 |-> !$past(ten_bit))
    else $error("7-bit match while 10-bit selected.");
  a_ctrl_write: assert property ( // RQ7
    @(posedge clk_in) disable iff (rst_in)
    wr_ctrl |=> ctrl_r == $past(ctrl_nxt))
    else $error("Control write lost.");
  a_data_only: assert property ( // RQ2
    @(posedge clk_in) disable iff (rst_in)
    data_strobe_out |-> addr_match_out || gcall_match_out)
    else $error("Data taken without address match.");
  a_stop_clears: assert property ( // RQ8
    @(posedge clk_in) disable iff (rst_in)
    stop_ev |=> !addr_match_out && !gcall_match_out && state_r == IDLE)
    else $error("Stop did not end transfer.");
  a_high_bits: assert property ( // RQ5
    @(posedge clk_in) disable iff (rst_in)
    state_r == ADDR1 && byte_done &&
    (byte_nxt[2:1] != ctrl_r[1:0] || ctrl_r[2]) |=> state_r != ADDR2)
    else $error("Ten-bit header accepted with wrong high bits.");
  a_ten_second: assert property ( // RQ9
    @(posedge clk_in) disable iff (rst_in)
    $rose(addr_match_out) && $past(state_r) == ADDR2
    |-> $past(ten_bit) && !$past(ctrl_r[2]) &&
    $past(byte_nxt) == own_low_r)
    else $error("Second address byte mismatch.");
  a_gc_ignored: assert property ( // RQ1
    @(posedge clk_in) disable iff (rst_in)
    state_r == ADDR1 && byte_done && !gc_en |=> !gcall_match_out)
    else $error("General call flagged while disabled.");
  a_gc_accept: assert property ( // RQ2
    @(posedge clk_in) disable iff (rst_in)
    state_r == ADDR1 && byte_done && gc_en &&
    byte_nxt[7:1] == GENERAL_CALL_ADDR |=> gcall_match_out)
    else $error("General call not recognised.");
  a_seven_bits: assert property ( // RQ3
    @(posedge clk_in) disable iff (rst_in)
    state_r == ADDR1 && byte_done && ten_bit |=> !addr_match_out)
    else $error("Single-byte match while 10-bit selected.");
  a_reserved_store: assert property ( // RQ6
    @(posedge clk_in) disable iff (rst_in)
    wr_ctrl |=> ctrl_r[5:3] == 3'b000)
    else $error("Reserved bits stored.");
  a_start_clears: assert property ( // RQ8
    @(posedge clk_in) disable iff (rst_in)
    start_ev |=> state_r == ADDR1 && !addr_match_out && !gcall_match_out)
    else $error("Start did not restart address phase.");
  a_low_write: assert property ( // RQ9
    @(posedge clk_in) disable iff (rst_in)
    wr_low |=> own_low_r == $past(wdata_in))
    else $error("Own address low write lost.");
endmodule // i2c_slave_address_config

//--- tb/bus_master_model.sv
// Bus master model that frames START, bytes and STOP on idle-high lines.
`timescale 1ns/1ps
module bus_master_model (
  // Bus lines.
  output logic scl_out,
  output logic sda_out
);
  localparam time H = 40ns;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic start();
    sda_out = 1'b1;
    #H scl_out = 1'b1;
    #H sda_out = 1'b0;
    #H scl_out = 1'b0;
  endtask
  // Data moves only while the clock is low; the ninth bit is released.
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #H sda_out = b[i];
      #H scl_out = 1'b1;
      #H scl_out = 1'b0;
    end
    #H sda_out = 1'b1;
    #H scl_out = 1'b1;
    #H scl_out = 1'b0;
  endtask
  task automatic stop();
    #H sda_out = 1'b0;
    #H scl_out = 1'b1;
    #H sda_out = 1'b1;
  endtask
endmodule // bus_master_model

//--- tb/tb_top.sv
// Self-checking bench for the slave address configuration block.
`timescale 1ns/1ps
module tb_top;
  import addr_cfg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out, data_out, d, v;
  logic scl, sda, match, gcall, strobe;
  logic [6:0] own;
  int n_fail = 0;
  int checked = 0;
  int n_strobe = 0;
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) if (strobe === 1'b1) n_strobe++;
  bus_master_model i_bus (.scl_out(scl), .sda_out(sda));
  i2c_slave_address_config i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .scl_in(scl), .sda_in(sda),
    .addr_match_out(match), .gcall_match_out(gcall),
    .data_strobe_out(strobe), .data_out(data_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
    return {w[7:6], 3'b000, w[2:0]};
  endfunction
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= x;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 x = rdata_out;
  endtask
  task automatic frame(input logic [7:0] b0, b1, input logic m, g, n);
    int n0;
    n0 = n_strobe;
    // Move line changes and checks 1 ns past the call; frames take 2401 ns, so the 2nd and 4th in a row land on a clock edge.
    #1;
    i_bus.start();
    i_bus.send(b0);
    i_bus.send(b1);
    check({7'h00, match}, {7'h00, m});
    check({7'h00, gcall}, {7'h00, g});
    check(8'(n_strobe - n0), {7'h00, n});
    if (n) check(data_out, b1);
    i_bus.stop();
  endtask
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------------
  initial begin
    d = 8'($urandom(32'h6331));
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_rd(OFS_BUS_CONTROL_TWO, d);
    check(d, CTRL_RESET);
    reg_rd(4'hF, d);
    check(d, 8'h00);
    reg_wr(OFS_BUS_CONTROL_TWO, 8'hFF);
    reg_rd(OFS_BUS_CONTROL_TWO, d);
    check(d, ctrl_exp(8'hFF));
    repeat (6) begin
      v = 8'($urandom);
      reg_wr(OFS_BUS_CONTROL_TWO, v);
      reg_rd(OFS_BUS_CONTROL_TWO, d);
      check(d, ctrl_exp(v));
    end
    own = 7'(8 + $urandom % 112);
    v = 8'($urandom);
    reg_wr(OFS_OWN_ADDR_LOW, {1'b0, own});
    reg_wr(OFS_BUS_CONTROL_TWO, 8'h00);
    frame({GENERAL_CALL_ADDR, 1'b0}, v, 0, 0, 0);
    frame({own, 1'b0}, 8'h5A, 1, 0, 1);
    frame({own ^ 7'h01, 1'b0}, 8'h3C, 0, 0, 0);
    reg_wr(OFS_BUS_CONTROL_TWO, 8'h80);
    frame({GENERAL_CALL_ADDR, 1'b0}, v, 0, 1, 1);
    reg_wr(OFS_BUS_CONTROL_TWO, 8'h43);
    frame({TEN_BIT_PREFIX, 2'b11, 1'b0}, {1'b0, own}, 1, 0, 0);
    frame({TEN_BIT_PREFIX, 2'b10, 1'b0}, {1'b0, own}, 0, 0, 0);
    frame({own, 1'b0}, 8'h00, 0, 0, 0);
    frame({TEN_BIT_PREFIX, 2'b11, 1'b0}, {1'b1, own}, 0, 0, 0);
    reg_wr(OFS_BUS_CONTROL_TWO, 8'h47);
    frame({TEN_BIT_PREFIX, 2'b11, 1'b0}, {1'b0, own}, 0, 0, 0);
    reg_rd(OFS_MATCH_STATUS, d);
    check(d, 8'h03);
    stop_test();
  end
  // The whole sequence needs about 22 us; this is a generous ceiling.
  initial begin
    #100us;
    n_fail++;
    stop_test();
  end
endmodule // tb_top
